// ### dv/fsp_cpu_model.sv
// cpu core model driving the flash sequencer bus
// assumes: strobe sampled at rising edge, read data one cycle later
`timescale 1ns/100ps
module fsp_cpu_model (
  input wire logic ref_clk_i, // clock
  output logic [15:0] bus_addr_o, // address
  output logic [15:0] bus_wdata_o, // write data
  output logic bus_wr_o, // write strobe
  output logic bus_rd_o, // read strobe
  output logic bus_byte_o, // byte access
  input wire logic [15:0] bus_rdata_i // read data
);
  // quiet bus at time zero
  initial begin
    bus_addr_o = 16'h0000;
    bus_wdata_o = 16'h0000;
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
    bus_byte_o = 1'b0;
  end
  // one write of a byte or word; released lines show inverted leftovers
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
    @(posedge ref_clk_i);
    bus_addr_o <= a;
    bus_wdata_o <= d;
    bus_byte_o <= b;
    bus_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    bus_wr_o <= 1'b0;
    bus_addr_o <= ~a;
    bus_wdata_o <= ~d;
  endtask : wr
  // one read; data taken in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    bus_addr_o <= a;
    bus_byte_o <= 1'b0;
    bus_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    bus_rd_o <= 1'b0;
    bus_addr_o <= ~a;
    #1;
    d = bus_rdata_i;
  endtask : rd
endmodule : fsp_cpu_model

// ### dv/fsp_flash_chk.sv
// port checker for the flash sequencer
// assumes: bound to fsp_flash_ctrl from the bench top file
`timescale 1ns/100ps
module fsp_flash_chk (
  input wire logic ref_clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic bus_wr_i, // cpu write
  input wire logic bus_rd_i, // cpu read
  input wire logic ext_req_i, // ext request
  input wire logic ext_ack_o, // ext taken
  input wire logic busy_o, // erase running
  input wire logic access_violation_ie_i, // violation enable
  input wire logic nonmaskable_pin_flag_i, // pin flag
  input wire logic nonmaskable_pin_ie_i, // pin enable
  input wire logic oscillator_fault_flag_i, // osc flag
  input wire logic oscillator_fault_ie_i, // osc enable
  input wire logic nmi_req_o, // vector request
  input wire logic [15:0] nmi_vector_o, // vector word
  input wire logic [3:0] nmi_priority_o // priority
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  logic [11:0] busy_cnt_q;
  logic [11:0] busy_cnt_d;
  // length of the running erase
  always_comb begin
    busy_cnt_d = busy_o ? busy_cnt_q + 12'h001 : 12'h000;
  end
  // register the count
  always_ff @(posedge ref_clk_i) begin
    busy_cnt_q <= reset_i ? 12'h000 : busy_cnt_d;
  end
  // ========================================
  // shared vector, handshake and erase length
  vec_word_a: assert property (nmi_vector_o == 16'hFFFC)
    else $error("vector word wrong");
  vec_prio_a: assert property (nmi_priority_o == 4'hE)
    else $error("vector priority wrong");
  pin_event_a: assert property (nonmaskable_pin_flag_i && nonmaskable_pin_ie_i |-> nmi_req_o)
    else $error("pin event lost");
  osc_fault_a: assert property (oscillator_fault_flag_i && oscillator_fault_ie_i |-> nmi_req_o)
    else $error("oscillator fault lost");
  nmi_quiet_a: assert property (!(nonmaskable_pin_flag_i && nonmaskable_pin_ie_i)
    && !(oscillator_fault_flag_i && oscillator_fault_ie_i) && !access_violation_ie_i
    |-> !nmi_req_o) else $error("request while all disabled");
  ack_cause_a: assert property (ext_ack_o |-> ext_req_i && !busy_o)
    else $error("ack without idle request");
  ack_idle_a: assert property (ext_req_i && !busy_o && !bus_wr_i && !bus_rd_i |-> ext_ack_o)
    else $error("idle request not taken");
  erase_bound_a: assert property (busy_cnt_q <= 12'h2BC)
    else $error("erase runs too long");
endmodule : fsp_flash_chk

// ### dv/tb_fsp_flash_ctrl.sv
// self-checking bench: cpu, tap and boot traffic on the flash sequencer
// assumes: 100 MHz clock, sync high reset, array starts erased
`timescale 1ns/100ps
module tb_fsp_flash_ctrl;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] ba, bw, brd, ea = 16'h0000, ed = 16'h0000, nvec;
  logic bwr, brdy, bby, ack, busy, nreq, er = 1'b0, eb = 1'b0, eby = 1'b0, av_ie = 1'b0;
  logic [1:0] eop = 2'h0;
  logic [3:0] nin = 4'h0, npri;
  logic [15:0] mem [int];
  logic [31:0] seed = 32'h00014455;
  int failures = 0;
  int tests_run = 0;
  // clock
  always #5 ref_clk_i = ~ref_clk_i;
  fsp_flash_ctrl #(.MAIN_SEGS(2)) fsp_flash_ctrl_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .bus_addr_i(ba), .bus_wdata_i(bw), .bus_wr_i(bwr), .bus_rd_i(brdy), .bus_byte_i(bby),
    .bus_rdata_o(brd), .ext_req_i(er), .ext_boot_i(eb), .ext_op_i(eop), .ext_addr_i(ea),
    .ext_data_i(ed), .ext_byte_i(eby), .ext_ack_o(ack), .busy_o(busy),
    .access_violation_ie_i(av_ie), .nonmaskable_pin_flag_i(nin[3]),
    .nonmaskable_pin_ie_i(nin[2]), .oscillator_fault_flag_i(nin[1]),
    .oscillator_fault_ie_i(nin[0]), .nmi_req_o(nreq), .nmi_vector_o(nvec),
    .nmi_priority_o(npri));
  fsp_cpu_model cpu (.ref_clk_i(ref_clk_i), .bus_addr_o(ba), .bus_wdata_o(bw),
    .bus_wr_o(bwr), .bus_rd_o(brdy), .bus_byte_o(bby), .bus_rdata_i(brd));
  // ========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic rdchk(input string n, input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    cpu.rd(a, d);
    chk(n, e, d);
  endtask : rdchk
  // programming only clears bits; a byte lands in the lane of addr[0]
  task automatic prog(input logic [15:0] a, input logic [15:0] d, input logic b);
    logic [15:0] w;
    w = {a[15:1], 1'b0};
    if (!mem.exists(w)) mem[w] = 16'hFFFF;
    mem[w] &= !b ? d : (a[0] ? {d[7:0], 8'hFF} : {8'hFF, d[7:0]});
    cpu.wr(a, d, b);
  endtask : prog
  task automatic wipe(input int lo, input int hi);
    foreach (mem[k]) if (k >= lo && k <= hi) mem[k] = 16'hFFFF;
  endtask : wipe
  task automatic verify();
    foreach (mem[k]) rdchk("array word", 16'(k), mem[k]);
  endtask : verify
  // one word per cycle at divider zero; bounded wait for the end
  task automatic wait_idle(input int words);
    int n;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= 2000) begin
      failures++;
      end_sim();
    end
    chk("erase cycles", 16'(words), 16'(n));
  endtask : wait_idle
  task automatic erase(input logic [15:0] c1, input logic [15:0] a, input int words);
    cpu.wr(16'h0128, c1, 1'b0);
    cpu.wr(a, 16'h0000, 1'b0);
    wait_idle(words);
  endtask : erase
  // tap or boot request held until taken
  task automatic ext(input logic b, input logic [1:0] op, input logic [15:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    er <= 1'b1;
    eb <= b;
    eop <= op;
    ea <= a;
    ed <= d;
    eby <= a[0]; // an odd address asks for a byte program
    @(negedge ref_clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 50) begin
      failures++;
      end_sim();
    end
    @(posedge ref_clk_i);
    er <= 1'b0;
    ea <= ~a;
    ed <= ~d;
  endtask : ext
  // ========================================
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rdchk("ctrl1 reset", 16'h0128, 16'h0000);
    rdchk("ctrl2 reset", 16'h012A, 16'h0002);
    rdchk("ctrl3 reset", 16'h012C, 16'h0010);
    rdchk("unmapped", 16'h0130, 16'h0000);
    cpu.wr(16'hFC00, 16'h1234, 1'b0);
    repeat (2) @(negedge ref_clk_i);
    chk("masked request", 16'h0000, {15'h0000, nreq});
    @(posedge ref_clk_i);
    av_ie <= 1'b1;
    @(negedge ref_clk_i);
    chk("violation request", 16'h0001, {15'h0000, nreq});
    rdchk("ctrl3 flag", 16'h012C, 16'h0014);
    cpu.wr(16'h012C, 16'h0000, 1'b0);
    repeat (2) @(negedge ref_clk_i);
    chk("cleared request", 16'h0000, {15'h0000, nreq});
    @(posedge ref_clk_i);
    av_ie <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_i);
      nin <= 4'(i);
      @(negedge ref_clk_i);
      chk("shared request", {15'h0000, (i[3] & i[2]) | (i[1] & i[0])}, {15'h0000, nreq});
    end
    chk("vector word", 16'hFFFC, nvec);
    chk("priority", 16'h000E, {12'h000, npri});
    cpu.wr(16'h012A, 16'h0000, 1'b0);
    erase(16'h0002, 16'h1000, 64);
    erase(16'h0002, 16'h1080, 64);
    rdchk("ctrl1 after erase", 16'h0128, 16'h0000);
    cpu.wr(16'h0128, 16'h0040, 1'b0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      prog({6'h3F, seed[9:1], seed[0] & seed[16]}, seed[31:16], seed[16]);
    end
    prog(16'h1000, 16'h0F0F, 1'b0);
    prog(16'h1081, 16'h00A5, 1'b1);
    verify();
    erase(16'h0002, 16'hFC10, 256);
    wipe(32'hFC00, 32'hFDFF);
    verify();
    erase(16'h0004, 16'hFE00, 512);
    wipe(32'hFC00, 32'hFFFF);
    verify();
    erase(16'h0006, 16'hFC00, 640);
    wipe(0, 32'hFFFF);
    verify();
    cpu.wr(16'h0128, 16'h0040, 1'b0);
    prog(16'hFE20, 16'hF0F0, 1'b0);
    rdchk("cpu source", 16'h012C, 16'h0100);
    cpu.wr(16'h012C, 16'h0010, 1'b0);
    ext(1'b0, 2'h0, 16'hFE20, 16'h5A5A);
    rdchk("tap program", 16'hFE20, 16'h5050);
    rdchk("tap source", 16'h012C, 16'h0210);
    ext(1'b1, 2'h0, 16'hFE21, 16'h00C3);
    rdchk("boot byte", 16'hFE20, 16'h4050);
    rdchk("boot source", 16'h012C, 16'h0310);
    for (int op = 1; op < 4; op++) begin
      ext(op[0], 2'(op), 16'hFE20, 16'h0000);
      wait_idle(op == 3 ? 640 : op * 256);
      rdchk("ext source", 16'h012C, op[0] ? 16'h0310 : 16'h0210);
    end
    rdchk("ext erased", 16'hFE20, 16'hFFFF);
    end_sim();
  end
endmodule : tb_fsp_flash_ctrl
bind fsp_flash_ctrl fsp_flash_chk fsp_flash_chk_inst (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .ext_req_i(ext_req_i),
  .ext_ack_o(ext_ack_o), .busy_o(busy_o), .access_violation_ie_i(access_violation_ie_i),
  .nonmaskable_pin_flag_i(nonmaskable_pin_flag_i), .nonmaskable_pin_ie_i(nonmaskable_pin_ie_i),
  .oscillator_fault_flag_i(oscillator_fault_flag_i),
  .oscillator_fault_ie_i(oscillator_fault_ie_i), .nmi_req_o(nmi_req_o),
  .nmi_vector_o(nmi_vector_o), .nmi_priority_o(nmi_priority_o));

// ### src/fsp_flash_array.sv
// word wide flash array model with byte lanes and registered read
// assumes: sequencer keeps write timing; contents start erased
`timescale 1ns/100ps
`include "fsp_map.svh"
module fsp_flash_array #(
  parameter int WORDS = 640,
  parameter int IW = 10
) (
  input wire logic ref_clk_i, // system clock
  fsp_mem_if.mem port         // access from the sequencer
);
  logic [15:0] mem_q [WORDS];
  logic [15:0] rdata_q;

  // ========================================
  // contents start erased
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem_q[i] = `FSP_ERASED;
    end
  end

  // erase sets lanes to ones, program only clears ones
  // plain always: the erased preload above also writes the cells
  always @(posedge ref_clk_i) begin
    if (port.we && (int'(port.addr) < WORDS)) begin
      for (int b = 0; b < 2; b++) begin
        if (port.be[b]) begin
          if (port.erase) begin
            mem_q[port.addr][b*8 +: 8] <= 8'(`FSP_ERASED);
          end else begin
            mem_q[port.addr][b*8 +: 8] <= mem_q[port.addr][b*8 +: 8] & port.wdata[b*8 +: 8];
          end
        end
      end
    end
    rdata_q <= (int'(port.addr) < WORDS) ? mem_q[port.addr] : `FSP_ERASED;
  end

  assign port.rdata = rdata_q;
endmodule : fsp_flash_array

// ### src/fsp_flash_ctrl.sv
// flash program and erase sequencer with cpu registers and two external sources
// assumes: cpu bus, tap and boot loader synchronous to ref_clk_i
`timescale 1ns/100ps
`include "fsp_map.svh"
module fsp_flash_ctrl #(
  parameter int MAIN_SEGS = 2,                  // number of main segments
  parameter logic [15:0] INFO_BASE = `FSP_INFO_BASE // byte address of info segment B
) (
  input wire logic ref_clk_i,               // system clock
  input wire logic reset_i,                 // synchronous reset, high
  input wire logic [15:0] bus_addr_i,       // cpu byte address
  input wire logic [15:0] bus_wdata_i,      // cpu write data
  input wire logic bus_wr_i,                // cpu write strobe
  input wire logic bus_rd_i,                // cpu read strobe
  input wire logic bus_byte_i,              // cpu byte access
  output logic [15:0] bus_rdata_o,          // read data, cycle after strobe
  input wire logic ext_req_i,               // tap or boot loader request
  input wire logic ext_boot_i,              // request from boot loader, else tap
  input wire logic [1:0] ext_op_i,          // requested operation
  input wire logic [15:0] ext_addr_i,       // target byte address
  input wire logic [15:0] ext_data_i,       // program data
  input wire logic ext_byte_i,              // byte program
  output logic ext_ack_o,                   // request taken
  output logic busy_o,                      // erase in progress
  input wire logic access_violation_ie_i,   // individual violation enable
  input wire logic nonmaskable_pin_flag_i,  // pin event flag
  input wire logic nonmaskable_pin_ie_i,    // pin event enable
  input wire logic oscillator_fault_flag_i, // oscillator fault flag
  input wire logic oscillator_fault_ie_i,   // oscillator fault enable
  output logic nmi_req_o,                   // shared vector request
  output logic [15:0] nmi_vector_o,         // shared vector word address
  output logic [3:0] nmi_priority_o         // shared vector priority
);
  localparam int WORDS = `FSP_INFO_WORDS + MAIN_SEGS * `FSP_MAIN_SEG_WORDS;
  localparam int IW = $clog2(WORDS);
  localparam logic [16:0] MAIN_BASE = `FSP_ADDR_TOP - 17'(MAIN_SEGS * `FSP_MAIN_SEG_BYTES);
  localparam logic [IW-1:0] LAST_IDX = IW'(WORDS - 1);
  localparam logic [IW-1:0] MAIN_IDX = IW'(`FSP_INFO_WORDS);

  fsp_mem_if #(.IW(IW)) mem_bus ();

  fsp_flash_array #(.WORDS(WORDS), .IW(IW)) u_array (
    .ref_clk_i(ref_clk_i),
    .port(mem_bus)
  );

  // ========================================
  // state
  fsp_pkg::fsp_state_t state_q, state_d;
  fsp_pkg::fsp_src_t src_q, src_d;
  logic erase_q, erase_d, meras_q, meras_d, wrt_q, wrt_d;
  logic [5:0] div_q, div_d, cnt_q, cnt_d;
  logic lock_q, lock_d, accv_q, accv_d;
  logic [IW-1:0] ptr_q, ptr_d, end_q, end_d;
  logic [15:0] rdata_q, rdata_d;
  logic rd_mem_q, rd_mem_d;

  // ========================================
  // request decode
  logic cpu_flash, ext_go, go, tick, violation;
  logic [15:0] r_addr, r_wdata;
  logic [16:0] off_main, off_info;
  logic r_main, r_info, r_byte;
  fsp_pkg::fsp_op_t r_op;
  logic r_op_ok;
  logic [IW-1:0] r_idx, seg_start, seg_end;

  // pick the cpu when it touches the array, else the external source
  always_comb begin
    cpu_flash = (bus_wr_i || bus_rd_i) &&
                ((({1'b0, bus_addr_i} >= MAIN_BASE)) ||
                 ((bus_addr_i >= INFO_BASE) &&
                  ({1'b0, bus_addr_i} < {1'b0, INFO_BASE} + 17'(`FSP_INFO_BYTES))));
    ext_go = ext_req_i && !cpu_flash && (state_q == fsp_pkg::FSP_ST_IDLE);
    r_addr = cpu_flash ? bus_addr_i : ext_addr_i;
    r_wdata = cpu_flash ? bus_wdata_i : ext_data_i;
    r_byte = cpu_flash ? bus_byte_i : ext_byte_i;
    off_main = {1'b0, r_addr} - MAIN_BASE;
    off_info = {1'b0, r_addr} - {1'b0, INFO_BASE};
    r_main = {1'b0, r_addr} >= MAIN_BASE;
    r_info = (r_addr >= INFO_BASE) && (off_info < 17'(`FSP_INFO_BYTES));
    r_op_ok = 1'b1;
    if (!cpu_flash) begin
      r_op = fsp_pkg::fsp_op_t'(ext_op_i);
    end else if (erase_q && meras_q) begin
      r_op = fsp_pkg::FSP_OP_ALL_ERASE;
    end else if (meras_q) begin
      r_op = fsp_pkg::FSP_OP_MAIN_ERASE;
    end else if (erase_q) begin
      r_op = fsp_pkg::FSP_OP_SEG_ERASE;
    end else begin
      r_op = fsp_pkg::FSP_OP_PROG;
      r_op_ok = wrt_q;
    end
    // word index and segment bounds of the addressed location
    if (r_main) begin
      r_idx = IW'(`FSP_INFO_WORDS + (off_main >> 1));
      seg_start = IW'(`FSP_INFO_WORDS +
                      ((off_main >> `FSP_MAIN_SEG_SHIFT) << (`FSP_MAIN_SEG_SHIFT - 1)));
      seg_end = IW'(seg_start + IW'(`FSP_MAIN_SEG_WORDS - 1));
    end else begin
      r_idx = IW'(off_info >> 1);
      seg_start = IW'((off_info >> `FSP_INFO_SEG_SHIFT) << (`FSP_INFO_SEG_SHIFT - 1));
      seg_end = IW'(seg_start + IW'((`FSP_INFO_WORDS / 2) - 1));
    end
  end

  // a cpu array access is refused while busy; a write is also refused while locked or with no mode chosen
  assign violation = cpu_flash && ((state_q != fsp_pkg::FSP_ST_IDLE) ||
                     (bus_wr_i && (lock_q || !r_op_ok)));
  assign go = (cpu_flash && bus_wr_i && !violation) || (ext_go && (r_main || r_info));
  assign tick = (cnt_q >= div_q); // a divider lowered to the count or below ticks at once, no wrap

  // ========================================
  // next state of sequencer, registers and array port
  always_comb begin
    state_d = state_q;
    src_d = src_q;
    erase_d = erase_q;
    meras_d = meras_q;
    wrt_d = wrt_q;
    div_d = div_q;
    lock_d = lock_q;
    ptr_d = ptr_q;
    end_d = end_q;
    cnt_d = tick ? 6'h00 : 6'(cnt_q + 6'h01);
    mem_bus.we = 1'b0;
    mem_bus.erase = 1'b0;
    mem_bus.addr = r_idx;
    mem_bus.wdata = r_byte ? {2{r_wdata[7:0]}} : r_wdata;
    mem_bus.be = r_byte ? (r_addr[0] ? 2'h2 : 2'h1) : 2'h3;
    // register writes from the cpu
    if (bus_wr_i && (bus_addr_i == `FSP_CTL1_OFS)) begin
      erase_d = bus_wdata_i[`FSP_CTL1_ERASE];
      meras_d = bus_wdata_i[`FSP_CTL1_MERAS];
      wrt_d = bus_wdata_i[`FSP_CTL1_WRT];
    end
    if (bus_wr_i && (bus_addr_i == `FSP_CTL2_OFS)) begin
      div_d = bus_wdata_i[`FSP_CTL2_DIV_HI:0];
    end
    if (bus_wr_i && (bus_addr_i == `FSP_CTL3_OFS)) begin
      lock_d = bus_wdata_i[`FSP_CTL3_LOCK];
    end
    case (state_q)
      fsp_pkg::FSP_ST_IDLE: begin
        if (go) begin
          src_d = cpu_flash ? fsp_pkg::FSP_SRC_CPU :
                  (ext_boot_i ? fsp_pkg::FSP_SRC_BOOT : fsp_pkg::FSP_SRC_TAP);
          case (r_op)
            fsp_pkg::FSP_OP_PROG: begin
              mem_bus.we = 1'b1;
            end
            fsp_pkg::FSP_OP_SEG_ERASE: begin
              state_d = fsp_pkg::FSP_ST_ERASE;
              ptr_d = seg_start;
              end_d = seg_end;
            end
            fsp_pkg::FSP_OP_MAIN_ERASE: begin
              state_d = fsp_pkg::FSP_ST_ERASE;
              ptr_d = MAIN_IDX;
              end_d = LAST_IDX;
            end
            default: begin
              state_d = fsp_pkg::FSP_ST_ERASE;
              ptr_d = '0;
              end_d = LAST_IDX;
            end
          endcase
        end
      end
      fsp_pkg::FSP_ST_ERASE: begin
        // one word per divider tick; cpu reads see the walking word
        mem_bus.addr = ptr_q;
        mem_bus.erase = 1'b1;
        mem_bus.be = 2'h3;
        mem_bus.we = tick;
        if (tick) begin
          ptr_d = IW'(ptr_q + IW'(1));
          if (ptr_q == end_q) begin
            state_d = fsp_pkg::FSP_ST_IDLE;
            erase_d = 1'b0;
            meras_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = fsp_pkg::FSP_ST_IDLE;
      end
    endcase
    // violation flag: a new violation wins over a clear in the same cycle
    accv_d = accv_q;
    if (bus_wr_i && (bus_addr_i == `FSP_CTL3_OFS)) begin
      accv_d = accv_q & bus_wdata_i[`FSP_CTL3_ACCV];
    end
    if (violation) begin
      accv_d = 1'b1;
    end
    // register read data, captured one cycle after the strobe
    rd_mem_d = bus_rd_i && cpu_flash;
    rdata_d = 16'h0000;
    if (bus_rd_i) begin
      case (bus_addr_i)
        `FSP_CTL1_OFS: begin
          rdata_d[`FSP_CTL1_ERASE] = erase_q;
          rdata_d[`FSP_CTL1_MERAS] = meras_q;
          rdata_d[`FSP_CTL1_WRT] = wrt_q;
        end
        `FSP_CTL2_OFS: begin
          rdata_d[`FSP_CTL2_DIV_HI:0] = div_q;
        end
        `FSP_CTL3_OFS: begin
          rdata_d[`FSP_CTL3_BUSY] = (state_q != fsp_pkg::FSP_ST_IDLE);
          rdata_d[`FSP_CTL3_ACCV] = accv_q;
          rdata_d[`FSP_CTL3_LOCK] = lock_q;
          rdata_d[`FSP_CTL3_SRC_HI:`FSP_CTL3_SRC_LO] = src_q;
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // ========================================
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= fsp_pkg::FSP_ST_IDLE;
      src_q <= fsp_pkg::FSP_SRC_NONE;
      erase_q <= 1'b0;
      meras_q <= 1'b0;
      wrt_q <= 1'b0;
      div_q <= `FSP_CTL2_DIV_RST;
      cnt_q <= 6'h00;
      lock_q <= `FSP_LOCK_RST;
      accv_q <= 1'b0;
      ptr_q <= '0;
      end_q <= '0;
      rdata_q <= 16'h0000;
      rd_mem_q <= 1'b0;
    end else begin
      state_q <= state_d;
      src_q <= src_d;
      erase_q <= erase_d;
      meras_q <= meras_d;
      wrt_q <= wrt_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      lock_q <= lock_d;
      accv_q <= accv_d;
      ptr_q <= ptr_d;
      end_q <= end_d;
      rdata_q <= rdata_d;
      rd_mem_q <= rd_mem_d;
    end
  end

  // ========================================
  // outputs; array read data leaves the array register directly
  assign bus_rdata_o = rd_mem_q ? mem_bus.rdata : rdata_q;
  assign ext_ack_o = ext_go;
  assign busy_o = (state_q != fsp_pkg::FSP_ST_IDLE);
  // global enable deliberately not an input here
  assign nmi_req_o = (accv_q & access_violation_ie_i) |
                     (nonmaskable_pin_flag_i & nonmaskable_pin_ie_i) |
                     (oscillator_fault_flag_i & oscillator_fault_ie_i);
  assign nmi_vector_o = `FSP_NMI_VECTOR;
  assign nmi_priority_o = `FSP_NMI_PRIORITY;
endmodule : fsp_flash_ctrl

// ### src/fsp_map.svh
// named offsets, field positions, reset values and sizes of the flash sequencer
// assumes: included by bare name from the sequencer design files
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
// ========================================
// register byte addresses on the cpu bus
`define FSP_CTL1_OFS 16'h0128
`define FSP_CTL2_OFS 16'h012A
`define FSP_CTL3_OFS 16'h012C
// ========================================
// field positions
`define FSP_CTL1_ERASE 1
`define FSP_CTL1_MERAS 2
`define FSP_CTL1_WRT 6
`define FSP_CTL2_DIV_HI 5
`define FSP_CTL3_BUSY 0
`define FSP_CTL3_ACCV 2
`define FSP_CTL3_LOCK 4
`define FSP_CTL3_SRC_LO 8
`define FSP_CTL3_SRC_HI 9
// ========================================
// reset values
`define FSP_CTL2_DIV_RST 6'h02
`define FSP_LOCK_RST 1'b1
// ========================================
// array geometry
`define FSP_MAIN_SEG_BYTES 512
`define FSP_MAIN_SEG_SHIFT 9
`define FSP_INFO_SEG_SHIFT 7
`define FSP_INFO_BYTES 256
`define FSP_INFO_WORDS 128
`define FSP_MAIN_SEG_WORDS 256
`define FSP_INFO_BASE 16'h1000
`define FSP_ADDR_TOP 17'h10000
`define FSP_ERASED 16'hFFFF
// ========================================
// shared interrupt vector
`define FSP_NMI_VECTOR 16'hFFFC
`define FSP_NMI_PRIORITY 4'hE
`endif

// ### src/fsp_mem_if.sv
// carrier between the sequencer and its flash array
// assumes: one clock shared by both ends
`timescale 1ns/100ps
interface fsp_mem_if #(
  parameter int IW = 9
);
  logic we;
  logic erase;
  logic [IW-1:0] addr;
  logic [15:0] wdata;
  logic [1:0] be;
  logic [15:0] rdata;
  modport ctl (output we, output erase, output addr, output wdata, output be, input rdata);
  modport mem (input we, input erase, input addr, input wdata, input be, output rdata);
endinterface : fsp_mem_if

// ### src/fsp_pkg.sv
// types shared by the flash sequencer files
// assumes: compiled before every other sequencer file
package fsp_pkg;
  // ========================================
  // sequencer states
  typedef enum logic [0:0] {
    FSP_ST_IDLE,
    FSP_ST_ERASE
  } fsp_state_t;
  // ========================================
  // operation requested by any source
  typedef enum logic [1:0] {
    FSP_OP_PROG,
    FSP_OP_SEG_ERASE,
    FSP_OP_MAIN_ERASE,
    FSP_OP_ALL_ERASE
  } fsp_op_t;
  // ========================================
  // source of the last accepted operation
  typedef enum logic [1:0] {
    FSP_SRC_NONE,
    FSP_SRC_CPU,
    FSP_SRC_TAP,
    FSP_SRC_BOOT
  } fsp_src_t;
endpackage : fsp_pkg
